// file: shared/mcfd_defs.vh
// Register map, command field layout and timing counts for the file datapath
`ifndef MCFD_DEFS_VH
`define MCFD_DEFS_VH

// Register offsets (byte addresses)
`define MCFD_CMD_OFF      8'h00
`define MCFD_STAT_OFF     8'h04
`define MCFD_FADDR_OFF    8'h08
`define MCFD_FDATA_OFF    8'h0c
`define MCFD_TREG_OFF     8'h10
`define MCFD_MADDR_OFF    8'h14
`define MCFD_MOD_OFF      8'h18
`define MCFD_IO_OFF       8'h1c

// Command fields
`define MCFD_OP_HI        15
`define MCFD_OP_LO        12
`define MCFD_F_HI         11
`define MCFD_F_LO         8
`define MCFD_C_HI         7
`define MCFD_C_LO         4
`define MCFD_D_HI         3
`define MCFD_D_LO         0

// Operation codes
`define MCFD_OP_EXEC      4'h0
`define MCFD_OP_CTRL      4'h1
`define MCFD_OP_LIT       4'h2
`define MCFD_OP_MEMRD     4'h3
`define MCFD_OP_MEMWR     4'h4
`define MCFD_OP_IOCTL     4'h5
`define MCFD_OP_SENSE     4'h6
`define MCFD_OP_SHR4      4'h7
`define MCFD_OP_ADD       4'h8
`define MCFD_OP_SUB       4'h9
`define MCFD_OP_OR        4'ha
`define MCFD_OP_COPY      4'hb
`define MCFD_OP_MOVE      4'hc
`define MCFD_OP_SHR       4'hd
`define MCFD_OP_AND       4'he
`define MCFD_OP_SHL       4'hf

// Control field bits
`define MCFD_C_FLAGS      0
`define MCFD_C_TSEL       1
`define MCFD_C_INH        2
`define MCFD_C_LINK       3

// Destination codes
`define MCFD_D_NONE       4'h0
`define MCFD_D_TREG       4'h1
`define MCFD_D_MADDR      4'h2
`define MCFD_D_MOD        4'h3
`define MCFD_D_OUT        4'h4
`define MCFD_D_MODIFY     4'h7

// Reset values
`define MCFD_RST_BYTE     8'h00
`define MCFD_RST_CMD      16'h0000

// Timing counts in clocks
`define MCFD_MEMRD_CLKS   3'd3
`define MCFD_MEMWR_CLKS   3'd4
`define MCFD_MOD_CLKS     3'd2
`define MCFD_IO_CLKS      3'd1

`endif

// file: design/mcfd_datapath.v
// Microcoded file-register datapath with AHB-Lite command and register port
// ==========================================================================
// How it works
// - Each command is one 16-bit word acting on files or registers.
// - Shifts move one bit per command, except shift right four; add and logic use 8-bit operands.
// - Memory data passes through the transfer register; addresses loaded by command.
// - No interrupts; software polls status and input lines.
// - Memory, modifier and I/O results need one to three extra clocks.
// - Memory write consumes the transfer register for four clocks; rewrites corrupt it.
// - Copy zero clears the selected file and destination together.
// - A memory command can also update a file or register.
// - An I/O control command can also update a file, output moves only.
// - Link takes the carry of arithmetic or the bit shifted out by a one-bit shift.
// - One-bit shift with file write inhibited updates link and the destination, not the file.
// - Adding or subtracting zero forces link to a fixed value.
// - Add-zero move to a register always clears link.
// - Shift right with enter-link puts link in the top bit.
// - Modifier is ORed into the upper byte of execute commands and of non-control destination-7 commands.
// - Control value two selects the transfer register as operand and destination.
// - Operation B copies and C moves; bits 11 to 8 name the file, low bits the destination.
// - A new modifier value takes effect at the second clock after load.
// - Word 7421 shifts file four right four; E421 ANDs file four into it.
// - Flags change only on flag-update operates or control commands.
// - Adding zero with write inhibited sets flags without changing the file.
// - Sense entry with flag update drives negative from switch three.
// - Copying link with flag update clears negative and sets zero only when link is clear.
// - Shift right four moves the upper nibble down and fills ones.
`timescale 1ns/1ps
`default_nettype none
`include "mcfd_defs.vh"

module mcfd_datapath (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [7:0]  mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         mem_wr,
  output reg         mem_rd,
  input  wire [7:0]  mem_rdata,
  output reg  [7:0]  io_out,
  output reg         io_strobe,
  output reg         input_strobe_reset,
  input  wire [7:0]  io_in,
  input  wire [7:0]  sense_sw
);

  // ========================================================================
  // Bus slave
  reg        ph_q;
  reg        ph_wr_q;
  reg  [7:0] ph_addr_q;
  wire       start = hsel & htrans[1] & hready;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_q      <= 1'b0;
      ph_wr_q   <= 1'b0;
      ph_addr_q <= `MCFD_RST_BYTE;
    end
    else
    begin
      ph_q      <= start;
      ph_wr_q   <= start & hwrite;
      ph_addr_q <= start ? haddr[7:0] : ph_addr_q;
    end
  end

  wire wr_en = ph_q & ph_wr_q;

  // ========================================================================
  // State
  reg  [7:0]  file_q [0:15];
  reg  [7:0]  t_q;
  reg  [7:0]  mod_q;
  reg  [7:0]  mod_eff_q;
  reg  [7:0]  mod_dly_q;
  reg         link_q;
  reg         flag_v_q;
  reg         flag_n_q;
  reg         flag_z_q;
  reg  [3:0]  faddr_q;
  reg  [15:0] last_cmd_q;
  reg  [2:0]  busy_q;
  reg  [2:0]  wrbusy_q;
  reg         corrupt_q;
  reg  [1:0]  strobe_age_q;

  function [3:0] fld4;
    input [15:0] w;
    input [3:0]  lo;
    begin
      fld4 = w[lo +: 4];
    end
  endfunction

  // ========================================================================
  // Command decode and ALU
  wire [15:0] raw   = hwdata[15:0];
  wire [3:0]  rop   = fld4(raw, 4'd12);
  wire [3:0]  rdst  = fld4(raw, 4'd0);
  wire        mod_apply = (rop == `MCFD_OP_EXEC) ||
                          ((rop != `MCFD_OP_CTRL) && (rdst == `MCFD_D_MODIFY));
  wire [15:0] cmd   = mod_apply ? (raw | {mod_eff_q, 8'h00}) : raw;
  wire [3:0]  op    = fld4(cmd, 4'd12);
  wire [3:0]  fsel  = fld4(cmd, 4'd8);
  wire [3:0]  cf    = fld4(cmd, 4'd4);
  wire [3:0]  dst   = fld4(cmd, 4'd0);
  wire        tsel  = (cf == 4'h2);
  wire        upd   = cf[`MCFD_C_FLAGS];
  wire        inh   = cf[`MCFD_C_INH];
  wire        elnk  = cf[`MCFD_C_LINK];
  wire [7:0]  fv    = file_q[fsel];
  wire [7:0]  opb   = tsel ? t_q : 8'h00;

  reg  [8:0]  sum;
  reg  [7:0]  res;
  reg         nlink;
  reg         wfile;
  reg         wdst;
  reg         fupd;
  reg         n_force;
  reg         n_val;

  always @*
  begin
    sum     = 9'h000;
    res     = fv;
    nlink   = link_q;
    wfile   = ~inh;
    wdst    = 1'b1;
    fupd    = upd;
    n_force = 1'b0;
    n_val   = 1'b0;
    case (op)
      `MCFD_OP_ADD:
      begin
        sum   = {1'b0, fv} + {1'b0, opb};
        res   = sum[7:0];
        nlink = sum[8];
      end
      `MCFD_OP_SUB:
      begin
        sum   = {1'b0, fv} + {1'b0, ~opb} + 9'h001;
        res   = sum[7:0];
        nlink = sum[8];
      end
      `MCFD_OP_OR:   res = fv | opb;
      `MCFD_OP_AND:  res = fv & opb;
      `MCFD_OP_COPY:
      begin
        res   = elnk ? {7'h00, link_q} : opb;
      end
      `MCFD_OP_MOVE:
      begin
        res   = fv;
        wfile = 1'b0;
      end
      `MCFD_OP_SHR:
      begin
        res   = {elnk ? link_q : fv[7], fv[7:1]};
        nlink = fv[0];
      end
      `MCFD_OP_SHL:
      begin
        res   = {fv[6:0], elnk ? link_q : 1'b0};
        nlink = fv[7];
      end
      `MCFD_OP_SHR4:
      begin
        res   = {4'hf, fv[7:4]};
      end
      `MCFD_OP_LIT:
      begin
        res   = cmd[7:0];
        wfile = 1'b1;
        wdst  = 1'b0;
        fupd  = 1'b0;
      end
      `MCFD_OP_SENSE:
      begin
        res     = sense_sw;
        wfile   = 1'b0;
        wdst    = 1'b0;
        n_force = 1'b1;
        n_val   = sense_sw[3];
      end
      `MCFD_OP_MEMRD, `MCFD_OP_MEMWR, `MCFD_OP_IOCTL:
      begin
        res   = fv;
      end
      `MCFD_OP_CTRL:
      begin
        res   = fv;
        wfile = 1'b0;
        wdst  = 1'b0;
        fupd  = 1'b1;
      end
      default:
      begin
        wfile = 1'b0;
        wdst  = 1'b0;
        fupd  = 1'b0;
      end
    endcase
  end

  // Only literal/fill ops use cmd[7:0]; others send results by destination code
  wire exec_go = wr_en && (ph_addr_q == `MCFD_CMD_OFF);
  wire is_io   = (op == `MCFD_OP_IOCTL);
  wire dst_t   = wdst && (tsel || (dst == `MCFD_D_TREG));
  // An I/O command may only carry an output move alongside
  wire dst_ok  = !is_io || (dst == `MCFD_D_OUT) || (dst == `MCFD_D_NONE);

  // ========================================================================
  // Datapath registers
  integer i;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < 16; i = i + 1)
        file_q[i] <= `MCFD_RST_BYTE;
      t_q          <= `MCFD_RST_BYTE;
      mod_q        <= `MCFD_RST_BYTE;
      mod_dly_q    <= `MCFD_RST_BYTE;
      mod_eff_q    <= `MCFD_RST_BYTE;
      link_q       <= 1'b0;
      flag_v_q     <= 1'b0;
      flag_n_q     <= 1'b0;
      flag_z_q     <= 1'b0;
      faddr_q      <= 4'h0;
      last_cmd_q   <= `MCFD_RST_CMD;
      busy_q       <= 3'd0;
      wrbusy_q     <= 3'd0;
      corrupt_q    <= 1'b0;
      strobe_age_q <= 2'd0;
      mem_addr     <= `MCFD_RST_BYTE;
      mem_wdata    <= `MCFD_RST_BYTE;
      mem_wr       <= 1'b0;
      mem_rd       <= 1'b0;
      io_out       <= `MCFD_RST_BYTE;
      io_strobe    <= 1'b0;
      input_strobe_reset <= 1'b0;
    end
    else
    begin
      // A new modifier value passes two stages before commands see it
      mod_dly_q <= mod_q;
      mod_eff_q <= mod_dly_q;
      mem_wr    <= 1'b0;
      mem_rd    <= 1'b0;
      io_strobe <= 1'b0;
      input_strobe_reset <= 1'b0;
      busy_q    <= (busy_q != 3'd0) ? busy_q - 3'd1 : 3'd0;
      wrbusy_q  <= (wrbusy_q != 3'd0) ? wrbusy_q - 3'd1 : 3'd0;
      if (strobe_age_q != 2'd0 && strobe_age_q != 2'd3)
        strobe_age_q <= strobe_age_q + 2'd1;
      if (exec_go)
      begin
        last_cmd_q <= cmd;
        if (wfile)
          file_q[fsel] <= res;
        if (dst_t && dst_ok)
        begin
          t_q <= res;
          if (wrbusy_q != 3'd0)
            corrupt_q <= 1'b1;
        end
        if (wdst && dst_ok && !tsel)
        begin
          case (dst)
            `MCFD_D_MADDR: mem_addr <= res;
            `MCFD_D_MOD:
            begin
              mod_q  <= res;
              busy_q <= `MCFD_MOD_CLKS;
            end
            `MCFD_D_OUT:   io_out <= res;
            default:       mod_q <= mod_q;
          endcase
        end
        if (op == `MCFD_OP_ADD || op == `MCFD_OP_SUB ||
            op == `MCFD_OP_SHR || op == `MCFD_OP_SHL)
          link_q <= nlink;
        if (fupd)
        begin
          flag_n_q <= n_force ? n_val : res[7];
          flag_z_q <= (res == 8'h00);
          flag_v_q <= (op == `MCFD_OP_ADD || op == `MCFD_OP_SUB) ?
                      (sum[8] ^ sum[7] ^ fv[7] ^ opb[7] ^ (op == `MCFD_OP_SUB)) : 1'b0;
        end
        case (op)
          `MCFD_OP_MEMRD:
          begin
            mem_rd <= 1'b1;
            busy_q <= `MCFD_MEMRD_CLKS;
          end
          `MCFD_OP_MEMWR:
          begin
            mem_wr    <= 1'b1;
            mem_wdata <= t_q;
            wrbusy_q  <= `MCFD_MEMWR_CLKS;
            // Set wins: a T write landing on a still-running write keeps the mark
            corrupt_q <= dst_t && dst_ok && (wrbusy_q != 3'd0);
          end
          `MCFD_OP_IOCTL:
          begin
            if (cmd[`MCFD_C_LO])
            begin
              input_strobe_reset <= 1'b1;
              strobe_age_q <= 2'd1;
            end
            else
              io_strobe <= 1'b1;
            busy_q <= `MCFD_IO_CLKS;
          end
          default: ;
        endcase
      end
      else if (wr_en)
      begin
        case (ph_addr_q)
          `MCFD_FADDR_OFF: faddr_q <= hwdata[3:0];
          `MCFD_FDATA_OFF: file_q[faddr_q] <= hwdata[7:0];
          `MCFD_TREG_OFF:
          begin
            t_q <= hwdata[7:0];
            if (wrbusy_q != 3'd0)
              corrupt_q <= 1'b1;
          end
          `MCFD_MADDR_OFF: mem_addr <= hwdata[7:0];
          `MCFD_MOD_OFF:
          begin
            mod_q  <= hwdata[7:0];
            busy_q <= `MCFD_MOD_CLKS;
          end
          default: faddr_q <= faddr_q;
        endcase
      end
      // Read data lands in the transfer register once memory answers
      if (busy_q == 3'd1 && last_cmd_q[15:12] == `MCFD_OP_MEMRD)
        t_q <= mem_rdata;
    end
  end

  // ========================================================================
  // Read mux; input data is only valid one clock after strobe reset
  wire in_ok = (strobe_age_q >= 2'd2);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (start && !hwrite)
    begin
      case (haddr[7:0])
        `MCFD_CMD_OFF:   hrdata <= {16'h0000, last_cmd_q};
        `MCFD_STAT_OFF:  hrdata <= {19'h00000, corrupt_q, wrbusy_q != 3'd0, busy_q != 3'd0,
                                    in_ok, 5'h00, link_q, flag_v_q, flag_n_q, flag_z_q};
        `MCFD_FADDR_OFF: hrdata <= {28'h0000000, faddr_q};
        `MCFD_FDATA_OFF: hrdata <= {24'h000000, file_q[faddr_q]};
        `MCFD_TREG_OFF:  hrdata <= {24'h000000, t_q};
        `MCFD_MADDR_OFF: hrdata <= {24'h000000, mem_addr};
        `MCFD_MOD_OFF:   hrdata <= {24'h000000, mod_q};
        `MCFD_IO_OFF:    hrdata <= {24'h000000, in_ok ? io_in : 8'h00};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: test/mcfd_checker.sv
// Port assertions for the file datapath
`timescale 1ns/1ps
`default_nettype none
module mcfd_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic        io_strobe,
  input wire logic        input_strobe_reset
);
  // ==========================================
  // Command data phase tracking
  logic       cmd_q;
  logic       cmd_d;
  logic [3:0] op;
  assign cmd_d = hsel & htrans[1] & hready & hwrite & (haddr[7:0] == 8'h00);
  assign op    = hwdata[15:12];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cmd_q <= 1'b0;
    else
      cmd_q <= cmd_d;
  // ==========================================
  // Assertions
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  AST_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  AST_WR_PULSE: assert property (mem_wr |=> !mem_wr) else $error("mem_wr too long");
  AST_RD_PULSE: assert property (mem_rd |=> !mem_rd) else $error("mem_rd too long");
  AST_WDATA_HELD: assert property (mem_wr |=> $stable(mem_wdata) [*3])
    else $error("write data changed during write");
  AST_CMD_WR: assert property (cmd_q && op == 4'h4 |-> ##[1:3] mem_wr)
    else $error("no memory write");
  AST_CMD_RD: assert property (cmd_q && op == 4'h3 |-> ##[1:3] mem_rd)
    else $error("no memory read");
  AST_CMD_ISR: assert property (cmd_q && op == 4'h5 && hwdata[4] |-> ##[1:3] input_strobe_reset)
    else $error("no strobe reset");
  AST_CMD_STB: assert property (cmd_q && op == 4'h5 && !hwdata[4] |-> ##[1:3] io_strobe)
    else $error("no io strobe");
  AST_ISR_PULSE: assert property (input_strobe_reset |=> !input_strobe_reset)
    else $error("strobe reset too long");
endmodule
`default_nettype wire

// file: test/mcfd_mem_model.sv
// Core memory and input device model
`timescale 1ns/1ps
`default_nettype none
module mcfd_mem_model (
  input wire logic        hclk,
  input wire logic [7:0]  mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  output logic [7:0]      mem_rdata,
  input wire logic        input_strobe_reset,
  input wire logic [7:0]  io_val,
  output logic [7:0]      io_in
);
  logic [7:0] mem [0:255];
  logic [1:0] hold_q;
  logic       pend_q;
  initial
  begin
    mem_rdata = 8'h00;
    io_in = 8'h00;
    hold_q = 2'd0;
    pend_q = 1'b0;
  end
  // Read data stands briefly, then toggles so a late sample is caught
  always @(posedge hclk)
  begin
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    if (mem_rd)
    begin
      mem_rdata <= mem[mem_addr];
      hold_q <= 2'd3;
    end
    else if (hold_q != 2'd0)
      hold_q <= hold_q - 2'd1;
    else
      mem_rdata <= ~mem_rdata;
    pend_q <= input_strobe_reset;
    if (pend_q)
      io_in <= io_val;
    else if (input_strobe_reset)
      io_in <= ~io_in;
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the file datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd_smp, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  sense_sw, io_val, v, t, a;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, mem_wr, mem_rd, io_strobe, input_strobe_reset;
  wire  [7:0]  mem_addr, mem_wdata, mem_rdata, io_in;
  int          n_errors, num_checks, i;
  mcfd_datapath mcfd_datapath_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .io_out(),
    .io_strobe(io_strobe), .input_strobe_reset(input_strobe_reset), .io_in(io_in), .sense_sw(sense_sw));
  mcfd_mem_model mcfd_mem_model_i (.hclk(hclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .input_strobe_reset(input_strobe_reset), .io_val(io_val), .io_in(io_in));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Read data is captured at the data phase edge itself
  always @(posedge hclk) rd_smp <= hrdata;
  // ==========================================
  // Tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    @(negedge hclk);
    r = rd_smp;
  endtask
  task cmd(input logic [15:0] c);
    bus(1'b1, 8'h00, {16'h0, c});
  endtask
  task rdf(input logic [3:0] f);
    bus(1'b1, 8'h08, {28'h0, f});
    bus(1'b0, 8'h0c, 32'h0);
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    close_out;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, sense_sw, io_val} = '0;
    hsize = 3'b010;
    n_errors = 0;
    num_checks = 0;
    i = $urandom(87);
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk("stat_reset", 32'h0, r);
    $display("reset test done");
    for (i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      cmd({8'h24, v});
      cmd(16'h7400);
      rdf(4'h4);
      chk("shr4", {24'h0, 4'hf, v[7:4]}, r);
    end
    $display("shift right four test done");
    for (i = 0; i < 2; i++)
    begin
      v = {i[0], 7'($urandom)};
      cmd({8'h25, v});
      cmd(16'hf540);
      bus(1'b0, 8'h04, 32'h0);
      chk("link", {31'h0, v[7]}, {31'h0, r[3]});
      rdf(4'h5);
      chk("inhibited_file", {24'h0, v}, r);
      cmd(16'hd5d0);
      bus(1'b0, 8'h04, 32'h0);
      chk("link_to_neg", {31'h0, v[7]}, {31'h0, r[1]});
      @(posedge hclk);
      sense_sw <= {4'($urandom), ~i[0], 3'($urandom)};
      cmd(16'h6150);
      bus(1'b0, 8'h04, 32'h0);
      chk("sense_neg", {31'h0, ~i[0]}, {31'h0, r[1]});
      cmd({8'h21, 8'($urandom)});
      bus(1'b0, 8'h04, 32'h0);
      chk("flag_hold", {31'h0, ~i[0]}, {31'h0, r[1]});
    end
    $display("link and flag test done");
    for (i = 0; i < 2; i++)
    begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      cmd({8'h26, v});
      cmd(16'h9650);
      bus(1'b0, 8'h04, 32'h0);
      chk("sub_zero_link", 32'h1, {31'h0, r[3]});
      cmd(16'h8601);
      bus(1'b0, 8'h04, 32'h0);
      chk("add_zero_link", 32'h0, {31'h0, r[3]});
      bus(1'b0, 8'h10, 32'h0);
      chk("add_zero_move", {24'h0, v}, r);
      cmd(16'h8650);
      bus(1'b0, 8'h04, 32'h0);
      chk("add_zero_flags", {30'h0, v[7], v == 8'h00}, {30'h0, r[1:0]});
      rdf(4'h6);
      chk("add_zero_file", {24'h0, v}, r);
      cmd(16'hc602);
      bus(1'b0, 8'h14, 32'h0);
      chk("move", {24'h0, v}, r);
      cmd(16'hb601);
      rdf(4'h6);
      chk("copy_zero_file", 32'h0, r);
      bus(1'b0, 8'h10, 32'h0);
      chk("copy_zero_dst", 32'h0, r);
      cmd(16'h9650);
      cmd(16'hb6d0);
      bus(1'b0, 8'h04, 32'h0);
      chk("copy_link_flags", 32'h0, {30'h0, r[1:0]});
    end
    $display("zero and copy test done");
    v = $urandom;
    t = $urandom;
    cmd({8'h24, v});
    bus(1'b1, 8'h10, {24'h0, t});
    bus(1'b1, 8'h18, 32'h74);
    repeat (2) @(posedge hclk);
    cmd(16'h0021);
    bus(1'b0, 8'h10, 32'h0);
    chk("mod_shr4", {24'h0, 4'hf, v[7:4]}, r);
    // The shift also rewrote file four, so put the operand back before the AND
    bus(1'b1, 8'h08, 32'h4);
    bus(1'b1, 8'h0c, {24'h0, v});
    bus(1'b1, 8'h10, {24'h0, t});
    bus(1'b1, 8'h18, 32'he4);
    repeat (2) @(posedge hclk);
    cmd(16'h0021);
    bus(1'b0, 8'h10, 32'h0);
    chk("mod_and", {24'h0, v & t}, r);
    bus(1'b0, 8'h00, 32'h0);
    chk("mod_word", 32'he421, r);
    $display("modifier test done");
    for (i = 0; i < 3; i++)
    begin
      a = $urandom;
      t = $urandom;
      bus(1'b1, 8'h14, {24'h0, a});
      bus(1'b1, 8'h10, {24'h0, t});
      cmd(16'h4000);
      repeat (4) @(posedge hclk);
      chk("mem_cell", {24'h0, t}, {24'h0, mcfd_mem_model_i.mem[a]});
      bus(1'b1, 8'h10, {24'h0, ~t});
      cmd(16'h3000);
      repeat (3) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0);
      chk("mem_read", {24'h0, t}, r);
      bus(1'b0, 8'h04, 32'h0);
      chk("no_corrupt", 32'h0, {31'h0, r[12]});
    end
    cmd(16'h4000);
    bus(1'b1, 8'h10, {24'h0, t});
    bus(1'b0, 8'h04, 32'h0);
    chk("corrupt", 32'h1, {31'h0, r[12]});
    $display("memory test done");
    @(posedge hclk);
    io_val <= $urandom;
    cmd(16'h5010);
    repeat (3) @(posedge hclk);
    bus(1'b0, 8'h1c, 32'h0);
    chk("io_in", {24'h0, io_val}, r);
    cmd(16'h5000);
    bus(1'b0, 8'h04, 32'h0);
    chk("input_ok", 32'h1, {31'h0, r[9]});
    $display("io test done");
    close_out;
  end
endmodule
bind mcfd_datapath mcfd_checker mcfd_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
  .mem_rd(mem_rd), .io_strobe(io_strobe), .input_strobe_reset(input_strobe_reset));
`default_nettype wire
